/* rtl/bbsr_pkg.sv */
package bbsr_pkg;

  // ==========================================================================
  // bus geometry
  localparam int unsigned BBSR_ADDR_W = 8;
  localparam int unsigned BBSR_DATA_W = 32;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] BBSR_OFS_PWR_FAIL = 8'h00;
  localparam logic [7:0] BBSR_OFS_REG_EN = 8'h08;

  // ==========================================================================
  // power-fail and reset status fields
  localparam int unsigned BBSR_BIT_TAMPER_EN = 0;
  localparam int unsigned BBSR_BIT_TAMPER_EVT = 1;
  localparam int unsigned BBSR_BIT_TAMPER_LVL = 2;
  localparam int unsigned BBSR_BIT_SUPPLY_ON = 3;
  localparam int unsigned BBSR_BIT_WDOG = 5;
  localparam int unsigned BBSR_BIT_BATT_POR = 7;

  // regulator enable field
  localparam int unsigned BBSR_BIT_REG_EN = 0;

  // ==========================================================================
  // sticky event flags, index inside the flag bank
  localparam int unsigned BBSR_NFLAGS = 3;
  localparam int unsigned BBSR_FLG_TAMPER = 0;
  localparam int unsigned BBSR_FLG_WDOG = 1;
  localparam int unsigned BBSR_FLG_BATT = 2;

  // ==========================================================================
  // values after a battery power-on reset
  localparam logic BBSR_RST_TAMPER_EN = 1'b1;
  localparam logic BBSR_RST_SUPPLY_ON = 1'b0;
  localparam logic [BBSR_NFLAGS-1:0] BBSR_RST_FLAGS = 3'h5;
  localparam logic [15:0] BBSR_RST_REG_EN = 16'h0001;
  localparam logic BBSR_RST_PIN_LEVEL = 1'b1;

endpackage

/* rtl/bbsr_flag_if.sv */
`timescale 1ns/1ps
interface bbsr_flag_if #(
  parameter int unsigned N = 3
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;

  modport bank (
    input set,
    input clr,
    output q
  );

  modport user (
    output set,
    output clr,
    input q
  );
endinterface

/* rtl/bbsr_sticky_flags.sv */
`timescale 1ns/1ps
module bbsr_sticky_flags
  import bbsr_pkg::*;
#(
  parameter int unsigned N = 3,
  parameter logic [N-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  bbsr_flag_if.bank flags
);

  // ==========================================================================
  // parameter check
  generate
    if (N < 1) begin : g_bad_n
      $error("bbsr_sticky_flags needs at least one flag");
    end
  endgenerate

  // ==========================================================================
  // one sticky bit per event; a set in the clearing cycle wins
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      logic flag_q;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_q <= RESET_VAL[i];
        end else if (ce) begin
          if (flags.set[i]) begin
            flag_q <= 1'b1;
          end else if (flags.clr[i]) begin
            flag_q <= 1'b0;
          end
        end
      end
      assign flags.q[i] = flag_q;
    end
  endgenerate

endmodule

/* rtl/bbsr_regs.sv */
`timescale 1ns/1ps
module bbsr_regs
  import bbsr_pkg::*;
#(
  parameter int unsigned ADDR_W = BBSR_ADDR_W,
  parameter int unsigned DATA_W = BBSR_DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  output logic [DATA_W-1:0] bus_rdata_q,
  output logic bus_ready_q,
  output logic bus_error_q,
  input wire logic tamper_n,
  input wire logic sleep_s3_n,
  input wire logic supply_good_in,
  input wire logic standby_rail,
  input wire logic standby_por,
  input wire logic battery_low,
  input wire logic watchdog_reset,
  output logic tamper_detect_enable_q,
  output logic tamper_pin_level_q,
  output logic supply_was_on_q,
  output logic [BBSR_NFLAGS-1:0] event_flags_q,
  output logic event_pending_q,
  output logic standby_regulator_enable_q
);

  // ==========================================================================
  // parameter check
  generate
    if (ADDR_W < 8 || DATA_W < 16) begin : g_bad_width
      $error("bbsr_regs needs ADDR_W >= 8 and DATA_W >= 16");
    end
  endgenerate

  // ==========================================================================
  // address decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_hit = (a == ADDR_W'(ofs));
  endfunction

  logic bus_live;
  logic hit_pf;
  logic hit_re;
  logic wr_pf;
  logic wr_re;

  // firmware cannot reach the bank while the standby rail is down
  assign bus_live = bus_sel && standby_rail;
  assign hit_pf = addr_hit(bus_addr, BBSR_OFS_PWR_FAIL);
  assign hit_re = addr_hit(bus_addr, BBSR_OFS_REG_EN);
  assign wr_pf = bus_live && bus_write && hit_pf;
  assign wr_re = bus_live && bus_write && hit_re;

  // ==========================================================================
  // sticky event flags
  bbsr_flag_if #(.N(BBSR_NFLAGS)) flg ();

  // tamper and battery flags reset to one
  bbsr_sticky_flags #(
    .N(BBSR_NFLAGS),
    .RESET_VAL(BBSR_RST_FLAGS)
  ) u_flags (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .flags(flg)
  );

  // ==========================================================================
  // tamper detection
  logic tamper_prev_q;
  logic tamper_edge;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tamper_prev_q <= BBSR_RST_PIN_LEVEL;
    end else if (ce) begin
      tamper_prev_q <= tamper_n;
    end
  end

  assign tamper_edge = (tamper_prev_q != tamper_n) && tamper_detect_enable_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tamper_detect_enable_q <= BBSR_RST_TAMPER_EN;
    end else if (ce && wr_pf) begin
      tamper_detect_enable_q <= bus_wdata[BBSR_BIT_TAMPER_EN];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tamper_pin_level_q <= BBSR_RST_PIN_LEVEL;
    end else if (ce) begin
      tamper_pin_level_q <= tamper_n;
    end
  end

  // ==========================================================================
  // supply state capture
  logic supply_good_prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_good_prev_q <= 1'b0;
    end else if (ce) begin
      supply_good_prev_q <= supply_good_in;
    end
  end

  // sample sleep level on supply-good fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_was_on_q <= BBSR_RST_SUPPLY_ON;
    end else if (ce && supply_good_prev_q && !supply_good_in) begin
      supply_was_on_q <= sleep_s3_n;
    end
  end

  // ==========================================================================
  // flag set and clear terms
  always_comb begin
    flg.set = '0;
    flg.clr = '0;
    flg.set[BBSR_FLG_TAMPER] = tamper_edge;
    flg.set[BBSR_FLG_WDOG] = watchdog_reset && standby_rail;
    flg.set[BBSR_FLG_BATT] = standby_por && battery_low;
    flg.clr[BBSR_FLG_TAMPER] = wr_pf && bus_wdata[BBSR_BIT_TAMPER_EVT];
    flg.clr[BBSR_FLG_WDOG] = wr_pf && bus_wdata[BBSR_BIT_WDOG];
    flg.clr[BBSR_FLG_BATT] = wr_pf && bus_wdata[BBSR_BIT_BATT_POR];
  end

  // ==========================================================================
  // regulator enable
  // zero turns regulator off; reset restores one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_regulator_enable_q <= BBSR_RST_REG_EN[BBSR_BIT_REG_EN];
    end else if (ce && wr_re) begin
      standby_regulator_enable_q <= bus_wdata[BBSR_BIT_REG_EN];
    end
  end

  // ==========================================================================
  // event routing
  // registered copy of the flags for interrupt logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_flags_q <= BBSR_RST_FLAGS;
      event_pending_q <= |BBSR_RST_FLAGS;
    end else if (ce) begin
      event_flags_q <= flg.q;
      event_pending_q <= |flg.q;
    end
  end

  // ==========================================================================
  // read data
  logic [DATA_W-1:0] pf_word;
  logic [DATA_W-1:0] re_word;

  always_comb begin
    pf_word = '0;
    pf_word[BBSR_BIT_TAMPER_EN] = tamper_detect_enable_q;
    pf_word[BBSR_BIT_TAMPER_EVT] = flg.q[BBSR_FLG_TAMPER];
    pf_word[BBSR_BIT_TAMPER_LVL] = tamper_pin_level_q;
    pf_word[BBSR_BIT_SUPPLY_ON] = supply_was_on_q;
    pf_word[BBSR_BIT_WDOG] = flg.q[BBSR_FLG_WDOG];
    pf_word[BBSR_BIT_BATT_POR] = flg.q[BBSR_FLG_BATT];
    re_word = '0;
    re_word[BBSR_BIT_REG_EN] = standby_regulator_enable_q;
  end

  // ==========================================================================
  // bus answer, one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata_q <= '0;
      bus_ready_q <= 1'b0;
      bus_error_q <= 1'b0;
    end else if (ce) begin
      bus_ready_q <= bus_live;
      bus_error_q <= bus_live && !(hit_pf || hit_re);
      if (bus_live && !bus_write && hit_pf) begin
        bus_rdata_q <= pf_word;
      end else if (bus_live && !bus_write && hit_re) begin
        bus_rdata_q <= re_word;
      end else begin
        bus_rdata_q <= '0;
      end
    end
  end

endmodule

/* testbench/bbsr_regs_props.sv */
`timescale 1ns/1ps
// ========
// checks
module bbsr_regs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bus_sel,
  input wire logic bus_write,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata_q,
  input wire logic bus_ready_q,
  input wire logic bus_error_q,
  input wire logic tamper_n,
  input wire logic sleep_s3_n,
  input wire logic supply_good_in,
  input wire logic standby_rail,
  input wire logic standby_por,
  input wire logic battery_low,
  input wire logic watchdog_reset,
  input wire logic supply_was_on_q,
  input wire logic tamper_detect_enable_q,
  input wire logic [2:0] event_flags_q,
  input wire logic event_pending_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire clr_t = ce && bus_sel && bus_write && standby_rail && bus_addr == 8'h00 && bus_wdata[1];
  property p_rdy; ce && bus_sel && standby_rail |=> bus_ready_q; endproperty
  property p_nrdy; ce && !(bus_sel && standby_rail) |=> !bus_ready_q; endproperty
  property p_err; bus_error_q |-> bus_ready_q && bus_rdata_q == 32'h0; endproperty
  property p_tmp;
    ce && $past(ce) && tamper_detect_enable_q && $changed(tamper_n) ##1 ce |=> event_flags_q[0];
  endproperty
  property p_clr; $fell(event_flags_q[0]) && $past(ce) && $past(ce, 2) |-> $past(clr_t, 2); endproperty
  property p_sup; ce && $past(ce) && $fell(supply_good_in) |=> supply_was_on_q == $past(sleep_s3_n); endproperty
  property p_wdg; ce && watchdog_reset && standby_rail ##1 ce |=> event_flags_q[1]; endproperty
  property p_bat; ce && standby_por && battery_low ##1 ce |=> event_flags_q[2]; endproperty
  property p_pnd; event_pending_q == |event_flags_q; endproperty
  a_rdy: assert property (p_rdy) else $error("no bus ready");
  a_nrdy: assert property (p_nrdy) else $error("stray bus ready");
  a_err: assert property (p_err) else $error("error with data");
  a_tmp: assert property (p_tmp) else $error("tamper edge lost");
  a_clr: assert property (p_clr) else $error("tamper flag dropped");
  a_sup: assert property (p_sup) else $error("supply state wrong");
  a_wdg: assert property (p_wdg) else $error("watchdog flag lost");
  a_bat: assert property (p_bat) else $error("battery flag lost");
  a_pnd: assert property (p_pnd) else $error("pending mismatch");
  c_err: cover property (bus_error_q);
  c_tmp: cover property ($rose(event_flags_q[0]));
  c_wdg: cover property ($rose(event_flags_q[1]));
  c_sup: cover property ($fell(supply_good_in));
endmodule
bind bbsr_regs bbsr_regs_props u_props (.*);

/* testbench/bbsr_regs_bench.sv */
`timescale 1ns/1ps
module bbsr_regs_bench;
  logic clk = 0, rst = 1, sel = 0, wr = 0, tn = 1, slp = 1, sg = 1, rl = 1, por = 0, lo = 0, wd = 0, ce_in = 1;
  logic [7:0] ad = 0;
  logic [31:0] wdat = 0, r = 32'h02E35E79, rd;
  logic [2:0] fl;
  logic rdy, er, en, lvl, sup, pend, rg;
  bit m_en, m_tp, m_lv, m_su, m_wf, m_bt, m_rg, m_th, m_sg, eb, ee;
  bit [31:0] ed;
  bit [2:0] pf;
  bit [33:0] exp_q[$];
  int bad_count = 0, compares = 0, cyc = 0;
  bbsr_regs u_dut (.clk(clk), .rst(rst), .ce(ce_in), .bus_sel(sel), .bus_write(wr), .bus_addr(ad),
    .bus_wdata(wdat), .bus_rdata_q(rd), .bus_ready_q(rdy), .bus_error_q(er), .tamper_n(tn),
    .sleep_s3_n(slp), .supply_good_in(sg), .standby_rail(rl), .standby_por(por), .battery_low(lo),
    .watchdog_reset(wd), .tamper_detect_enable_q(en), .tamper_pin_level_q(lvl), .supply_was_on_q(sup),
    .event_flags_q(fl), .event_pending_q(pend), .standby_regulator_enable_q(rg));
  always #12.5 clk = ~clk;
  function logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task stop_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task chk(input logic [39:0] s, input logic [39:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  // ========
  // model
  task step(input bit rnd);
    bit w, ev;
    bit [33:0] eq;
    eq = exp_q.pop_front();
    chk({rdy, er, rd}, eq);
    chk({fl, pend}, {pf, |pf});
    chk({en, sup, lvl, rg}, {m_en, m_su, m_lv, m_rg});
    if (rnd) begin
      r = nx(r);
      ce_in = r[31:29] != 0;
      sel = r[10] & r[11];
      wr = r[12];
      ad = {4'h0, r[9:8], 2'b00};
      rl = |r[15:13];
      wd = r[20:16] == 0;
      por = r[24:21] == 0;
      lo = r[25];
      slp = r[26];
      if (r[3:0] == 0) tn = ~tn;
      if (r[7:4] == 0) sg = ~sg;
      r = nx(r);
      wdat = r & ~{31'h0, ad == 8'h08};
    end
    if (!ce_in) begin
      // frozen clock enable: every output holds
      exp_q.push_back(eq);
    end else begin
      pf = {m_bt, m_wf, m_tp};
      eb = sel && rl;
      ee = eb && ad[2];
      ed = (!eb || ad[2] || wr) ? 0 : ad[3] ? {31'h0, m_rg} : {m_bt, 1'b0, m_wf, 1'b0, m_su, m_lv, m_tp, m_en};
      w = eb && wr;
      ev = m_en && (tn != m_th);
      if (w && ad == 8'h00) begin
        m_en = wdat[0];
        m_tp &= !wdat[1];
        m_wf &= !wdat[5];
        m_bt &= !wdat[7];
      end
      if (w && ad == 8'h08) m_rg = wdat[0];
      m_tp |= ev;
      m_wf |= wd && rl;
      m_bt |= por && lo;
      if (m_sg && !sg) m_su = slp;
      m_sg = sg;
      m_th = tn;
      m_lv = tn;
      exp_q.push_back({eb, ee, ed});
    end
    @(negedge clk);
  endtask
  task acc(input logic [7:0] a, input bit w, input logic [31:0] d);
    sel = 1;
    wr = w;
    ad = a;
    wdat = d;
    step(0);
    sel = 0;
    step(0);
  endtask
  task por_rst;
    {rst, sel, tn, sg, wd, por, rl, lo} = 8'hB2;
    ce_in = 1;
    repeat (20) @(negedge clk);
    {m_en, m_tp, m_lv, m_su, m_wf, m_bt, m_rg, m_th, m_sg} = 9'h1CE;
    pf = 3'h5;
    exp_q.delete();
    exp_q.push_back(34'h0);
    rst = 0;
  endtask
  initial begin
    por_rst();
    acc(8'h00, 0, 0);
    acc(8'h08, 0, 0);
    acc(8'h04, 0, 0);
    acc(8'h0C, 1, 32'hFFFFFFFF);
    acc(8'h00, 1, 0);
    acc(8'h00, 1, 32'h2);
    tn = 0;
    step(0);
    tn = 1;
    acc(8'h00, 1, 1);
    tn = 0;
    acc(8'h00, 0, 0);
    acc(8'h00, 1, 32'hFFFFFFFF);
    rl = 0;
    wd = 1;
    acc(8'h00, 1, 32'h1);
    rl = 1;
    step(0);
    wd = 0;
    sg = 0;
    step(0);
    {por, lo, sg} = 3'h7;
    step(0);
    por = 0;
    acc(8'h00, 1, 32'hA0);
    acc(8'h08, 1, 0);
    acc(8'h08, 0, 0);
    $display("directed test done");
    repeat (3000) step(1);
    $display("random test done");
    por_rst();
    acc(8'h00, 0, 0);
    acc(8'h08, 0, 0);
    $display("reset test done");
    stop_test();
  end
endmodule
